// ==== rtl/bst_pkg.sv ====
package bst_pkg;

    // ****************************************
    // Clock and test clock timing
    // ****************************************
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TCK_PERIOD_NS  = 50;
    localparam int TCK_HIGH_NS    = 20;
    localparam int CAP_SETUP_NS   = 5;
    localparam int CAP_HOLD_NS    = 5;
    localparam int TCK_HALF_A     = (TCK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TCK_HALF_B     = (TCK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TCK_HALF_CYC   = (TCK_HALF_A > TCK_HALF_B) ? TCK_HALF_A : TCK_HALF_B;
    localparam int CAP_WIN_CYC    = (CAP_SETUP_NS + CAP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] RST_TMS_COUNT = 3'h5;

    // ****************************************
    // Register lengths and values
    // ****************************************
    localparam int IR_LEN   = 3;
    localparam int ID_LEN   = 32;
    localparam int BSR_LEN  = 109;
    localparam logic [6:0]  BSR_LEN_W    = 7'h6D;
    localparam logic [2:0]  IR_CAPTURE   = 3'h1;
    // Identification value is arbitrary
    localparam logic [31:0] ID_VALUE     = 32'h0000_0001;

    // ****************************************
    // Instruction codes
    // ****************************************
    localparam logic [2:0] INS_EXTEST  = 3'h0;
    localparam logic [2:0] INS_IDCODE  = 3'h1;
    localparam logic [2:0] INS_SAMPLEZ = 3'h2;
    localparam logic [2:0] INS_SAMPLE  = 3'h4;
    localparam logic [2:0] INS_BYPASS  = 3'h7;

    // ****************************************
    // Boundary cell positions
    // ****************************************
    localparam int BS_C_N     = 1;
    localparam int BS_C       = 2;
    localparam int BS_ECHO_P  = 47;
    localparam int BS_K       = 56;
    localparam int BS_K_N     = 57;
    localparam int BS_ECHO_N  = 65;
    localparam int BS_INTERN  = 109;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } bst_state_t;

    typedef enum logic [1:0] {
        DR_BSR, DR_ID, DR_BYP
    } bst_dr_t;

    // ****************************************
    // Controller next state
    // ****************************************
    function automatic bst_state_t bst_next(input bst_state_t s, input logic tms);
        case (s)
            TLR:     return tms ? TLR    : RTI;
            RTI:     return tms ? SEL_DR : RTI;
            SEL_DR:  return tms ? SEL_IR : CAP_DR;
            CAP_DR:  return tms ? EX1_DR : SH_DR;
            SH_DR:   return tms ? EX1_DR : SH_DR;
            EX1_DR:  return tms ? UPD_DR : PA_DR;
            PA_DR:   return tms ? EX2_DR : PA_DR;
            EX2_DR:  return tms ? UPD_DR : SH_DR;
            UPD_DR:  return tms ? SEL_DR : RTI;
            SEL_IR:  return tms ? TLR    : CAP_IR;
            CAP_IR:  return tms ? EX1_IR : SH_IR;
            SH_IR:   return tms ? EX1_IR : SH_IR;
            EX1_IR:  return tms ? UPD_IR : PA_IR;
            PA_IR:   return tms ? EX2_IR : PA_IR;
            EX2_IR:  return tms ? UPD_IR : SH_IR;
            UPD_IR:  return tms ? SEL_DR : RTI;
            default: return TLR;
        endcase
    endfunction

    // Reserved codes map to bypass
    function automatic bst_dr_t bst_dr_sel(input logic [2:0] ir);
        case (ir)
            INS_EXTEST, INS_SAMPLEZ, INS_SAMPLE: return DR_BSR;
            INS_IDCODE:                          return DR_ID;
            default:                             return DR_BYP;
        endcase
    endfunction

    function automatic logic bst_reserved(input logic [2:0] ir);
        return (ir == 3'h3) || (ir == 3'h5) || (ir == 3'h6);
    endfunction

endpackage

// ==== rtl/bst_if.sv ====
`timescale 1ns/10ps
interface bst_if;
    logic tck;
    logic tms;
    logic tms_oe_n;
    logic tdi;
    logic tdi_oe_n;
    logic tdo;
    logic tdo_oe_n;
    logic tdo_line;

    // Floating data out reads high
    assign tdo_line = tdo_oe_n ? 1'b1 : tdo;

    modport dev  (input tck, tms, tms_oe_n, tdi, tdi_oe_n, output tdo, tdo_oe_n);
    modport host (output tck, tms, tms_oe_n, tdi, tdi_oe_n, input tdo_line);
endinterface

// ==== rtl/bst_tap_dev.sv ====
// Functional notes
// - Five high mode-select edges reset, no reset pin
// - Power-up forces controller reset state
// - Sample on rising, data out on falling
// - Mode select level steers every transition
// - State and instruction choose serial register
// - Three, one, thirty-two and 109-bit registers
// - Fixed instruction decode, three reserved codes
// - External test drives outputs, captures inputs
// - Identification loaded at capture, then shifted
// - Identification instruction after any reset
// - Sample-floated floats outputs, captures inputs
// - Sample captures input and I/O levels
// - Bypass gives one-bit scan path
// - Controller never loads reserved codes
// - Power-up needed after external test
// - Clock recovery cycles after scan activity
// - Inputs stable around boundary capture
// - Cell order: /C bit1, C bit2, internal 109
// - Echo strobes follow output clocks
// - Output clocks high: strobes follow input clocks
// - Data in and mode select pulled up
`timescale 1ns/10ps
module bst_tap_dev (
    // Clock and power-up reset
    input  wire logic           ref_clk,
    input  wire logic           reset_n,
    // Test pins
    bst_if.dev                  tap,
    // Memory balls
    input  wire logic [109:1]   ball_in,
    input  wire logic [109:1]   core_out,
    input  wire logic           core_oe_n,
    output logic      [109:1]   ball_out,
    output logic                ball_oe_n,
    // Echo strobes
    output logic                return_strobe_pos,
    output logic                return_strobe_neg,
    // Observation
    output logic      [2:0]     instr,
    output logic      [3:0]     tap_state
);

    // ****************************************
    // Cell classification
    // ****************************************
    function automatic logic out_cell(input int b);
        case (b)
            10, 13, 14, 17, 18, 21, 22, 25, 26, 30, 31, 34, 35, 38, 39, 42, 43, 46,
            47, 65, 66, 69, 70, 73, 74, 77, 78, 81, 82, 86, 87, 90, 91, 94, 95, 98,
            99, 102: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // ****************************************
    // Test pin sampling
    // ****************************************
    logic                   tck_q;
    logic                   tdo_q;
    logic                   tdo_oe_n_q;
    wire                    tck_rise;
    wire                    tck_fall;
    wire                    tms_lvl;
    wire                    tdi_lvl;

    assign tck_rise = tap.tck & ~tck_q;
    assign tck_fall = ~tap.tck & tck_q;
    assign tms_lvl  = tap.tms_oe_n ? 1'b1 : tap.tms;
    assign tdi_lvl  = tap.tdi_oe_n ? 1'b1 : tap.tdi;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tck_q <= 1'b0;
        end else begin
            tck_q <= tap.tck;
        end
    end

    // ****************************************
    // Controller
    // ****************************************
    bst_pkg::bst_state_t    state;
    bst_pkg::bst_state_t    next_state;

    // No reset pin: five high mode-select edges reach TLR from anywhere
    assign next_state = bst_pkg::bst_next(state, tms_lvl);
    assign tap_state  = state;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= bst_pkg::TLR;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // ****************************************
    // Instruction register
    // ****************************************
    logic [bst_pkg::IR_LEN-1:0]     ir;
    logic [bst_pkg::IR_LEN-1:0]     ir_sr;

    assign instr = ir;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ir    <= bst_pkg::INS_IDCODE;
            ir_sr <= bst_pkg::IR_CAPTURE;
        end else if (tck_rise) begin
            if (next_state == bst_pkg::TLR) begin
                ir <= bst_pkg::INS_IDCODE;
            end else if (state == bst_pkg::UPD_IR) begin
                ir <= ir_sr;
            end
            case (state)
                bst_pkg::CAP_IR: ir_sr <= bst_pkg::IR_CAPTURE;
                bst_pkg::SH_IR:  ir_sr <= {tdi_lvl, ir_sr[2:1]};
                default:         ir_sr <= ir_sr;
            endcase
        end
    end

    // ****************************************
    // Instruction decode
    // ****************************************
    bst_pkg::bst_dr_t       dr_sel;
    wire                    is_extest;
    wire                    is_samplez;
    wire                    is_sample;

    assign dr_sel     = bst_pkg::bst_dr_sel(ir);
    assign is_extest  = (ir == bst_pkg::INS_EXTEST);
    assign is_samplez = (ir == bst_pkg::INS_SAMPLEZ);
    assign is_sample  = (ir == bst_pkg::INS_SAMPLE);

    // ****************************************
    // Data registers
    // ****************************************
    logic                           byp;
    logic [bst_pkg::ID_LEN-1:0]     idr;
    logic [109:1]                   bsr;
    logic [109:1]                   upd;
    logic [109:1]                   cap_vec;

    // Internal cell captures zero
    always_comb begin
        cap_vec                     = ball_in;
        cap_vec[bst_pkg::BS_INTERN] = 1'b0;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            byp <= 1'b0;
            idr <= 32'h0000_0000;
            bsr <= '0;
        end else if (tck_rise) begin
            if (state == bst_pkg::CAP_DR) begin
                case (dr_sel)
                    bst_pkg::DR_ID:  idr <= bst_pkg::ID_VALUE;
                    bst_pkg::DR_BSR: bsr <= cap_vec;
                    default:         byp <= 1'b0;
                endcase
            end else if (state == bst_pkg::SH_DR) begin
                case (dr_sel)
                    bst_pkg::DR_ID:  idr <= {tdi_lvl, idr[31:1]};
                    bst_pkg::DR_BSR: bsr <= {tdi_lvl, bsr[109:2]};
                    default:         byp <= tdi_lvl;
                endcase
            end
        end
    end

    // Preloaded vector held for external test
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            upd <= '0;
        end else if (tck_rise && state == bst_pkg::UPD_DR && (is_extest || is_sample)) begin
            upd <= bsr;
        end
    end

    // ****************************************
    // Data out on falling edge
    // ****************************************
    logic                   next_tdo;
    wire                    shifting;

    assign shifting = (state == bst_pkg::SH_DR) || (state == bst_pkg::SH_IR);

    always_comb begin
        if (state == bst_pkg::SH_IR) begin
            next_tdo = ir_sr[0];
        end else begin
            case (dr_sel)
                bst_pkg::DR_ID:  next_tdo = idr[0];
                bst_pkg::DR_BSR: next_tdo = bsr[1];
                default:         next_tdo = byp;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tdo_q      <= 1'b0;
            tdo_oe_n_q <= 1'b1;
        end else if (tck_fall) begin
            tdo_q      <= next_tdo;
            tdo_oe_n_q <= ~shifting;
        end
    end

    assign tap.tdo      = tdo_q;
    assign tap.tdo_oe_n = tdo_oe_n_q;

    // ****************************************
    // Echo strobes and ball drive
    // ****************************************
    wire                    c_both_high;
    wire                    echo_pos;
    wire                    echo_neg;

    assign c_both_high = ball_in[bst_pkg::BS_C] & ball_in[bst_pkg::BS_C_N];
    assign echo_pos    = c_both_high ? ball_in[bst_pkg::BS_K]   : ball_in[bst_pkg::BS_C];
    assign echo_neg    = c_both_high ? ball_in[bst_pkg::BS_K_N] : ball_in[bst_pkg::BS_C_N];

    assign return_strobe_pos = is_extest ? upd[bst_pkg::BS_ECHO_P] : echo_pos;
    assign return_strobe_neg = is_extest ? upd[bst_pkg::BS_ECHO_N] : echo_neg;

    genvar gi;
    generate
        for (gi = 1; gi <= bst_pkg::BSR_LEN; gi++) begin : g_cell
            if (gi == bst_pkg::BS_ECHO_P) begin : g_spos
                assign ball_out[gi] = return_strobe_pos;
            end else if (gi == bst_pkg::BS_ECHO_N) begin : g_sneg
                assign ball_out[gi] = return_strobe_neg;
            end else if (out_cell(gi)) begin : g_out
                assign ball_out[gi] = is_extest ? upd[gi] : core_out[gi];
            end else begin : g_in
                assign ball_out[gi] = core_out[gi];
            end
        end
    endgenerate

    // Drivers on from instruction update under external test
    assign ball_oe_n = is_samplez ? 1'b1 : (is_extest ? 1'b0 : core_oe_n);

endmodule // bst_tap_dev

// ==== rtl/bst_tap_host.sv ====
`timescale 1ns/10ps
module bst_tap_host (
    // Clock and reset
    input  wire logic           ref_clk,
    input  wire logic           reset_n,
    // Test pins
    bst_if.host                 tap,
    // Scan request
    input  wire logic           req_valid,
    output logic                req_ready,
    input  wire logic           req_ir,
    input  wire logic [6:0]     req_len,
    input  wire logic [108:0]   req_data,
    // Scan answer
    output logic                rsp_valid,
    output logic      [108:0]   rsp_data,
    // Memory system control
    output logic                mem_hold_inputs,
    output logic                power_cycle_req,
    input  wire logic           power_cycle_done,
    output logic                recovery_req,
    input  wire logic           recovery_done
);

    // ****************************************
    // Test clock divider
    // ****************************************
    logic [3:0]             div;
    logic                   tck;
    wire                    div_wrap;
    wire                    rise_evt;
    wire                    fall_evt;

    assign div_wrap = (div == 4'(bst_pkg::TCK_HALF_CYC - 1));
    assign rise_evt = div_wrap & ~tck;
    assign fall_evt = div_wrap & tck;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            div <= 4'h0;
            tck <= 1'b0;
        end else begin
            div <= div_wrap ? 4'h0 : div + 4'h1;
            tck <= div_wrap ? ~tck : tck;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    typedef enum logic [3:0] {
        H_RST, H_IDLE, H_SEL, H_SELIR, H_CAP, H_TOSH, H_SHIFT, H_UPD, H_END
    } bst_host_t;

    bst_host_t              hs;
    bst_pkg::bst_state_t    mirror;
    logic [2:0]             rst_cnt;
    logic [6:0]             len;
    logic [6:0]             bit_cnt;
    logic                   is_ir;
    logic                   was_extest;
    logic [108:0]           sh;
    logic [108:0]           next_sh;
    logic                   tms_q;
    logic                   tdi_q;
    logic                   tms_val;
    logic                   cap_after;
    wire                    accept;
    wire                    done;
    wire  [2:0]             safe_ir;
    wire  [6:0]             len_clip;

    assign req_ready = (hs == H_IDLE) & rise_evt;
    assign accept    = req_valid & req_ready;
    assign done      = rise_evt & (hs == H_END);
    assign safe_ir   = bst_pkg::bst_reserved(req_data[2:0]) ? bst_pkg::INS_BYPASS : req_data[2:0];
    assign len_clip  = (req_len == 7'h00) ? 7'h01 : ((req_len > bst_pkg::BSR_LEN_W) ? bst_pkg::BSR_LEN_W : req_len);

    always_comb begin
        case (hs)
            H_RST:   tms_val = (rst_cnt != bst_pkg::RST_TMS_COUNT);
            H_SEL:   tms_val = 1'b1;
            H_SELIR: tms_val = 1'b1;
            H_SHIFT: tms_val = (bit_cnt == len - 7'h01);
            H_UPD:   tms_val = 1'b1;
            default: tms_val = 1'b0;
        endcase
    end

    always_comb begin
        next_sh          = {1'b0, sh[108:1]};
        next_sh[len - 7'h01] = tap.tdo_line;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tms_q <= 1'b1;
            tdi_q <= 1'b1;
        end else if (fall_evt) begin
            tms_q <= tms_val;
            tdi_q <= sh[0];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mirror <= bst_pkg::TLR;
        end else if (rise_evt) begin
            mirror <= bst_pkg::bst_next(mirror, tms_q);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hs      <= H_RST;
            rst_cnt <= 3'h0;
            len     <= 7'h01;
            bit_cnt <= 7'h00;
            is_ir   <= 1'b0;
            sh      <= '0;
        end else if (accept) begin
            hs      <= H_SEL;
            is_ir   <= req_ir;
            len     <= req_ir ? 7'(bst_pkg::IR_LEN) : len_clip;
            sh      <= req_ir ? {106'h0, safe_ir} : req_data;
            bit_cnt <= 7'h00;
        end else if (rise_evt) begin
            case (hs)
                H_RST: begin
                    rst_cnt <= rst_cnt + 3'h1;
                    hs      <= (rst_cnt == bst_pkg::RST_TMS_COUNT) ? H_IDLE : H_RST;
                end
                H_SEL:   hs <= is_ir ? H_SELIR : H_CAP;
                H_SELIR: hs <= H_CAP;
                H_CAP:   hs <= H_TOSH;
                H_TOSH:  hs <= H_SHIFT;
                H_SHIFT: begin
                    sh      <= next_sh;
                    bit_cnt <= bit_cnt + 7'h01;
                    hs      <= (bit_cnt == len - 7'h01) ? H_UPD : H_SHIFT;
                end
                H_UPD:   hs <= H_END;
                H_END:   hs <= H_IDLE;
                default: hs <= hs;
            endcase
        end
    end

    // ****************************************
    // Answer and memory system flags
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid       <= 1'b0;
            rsp_data        <= '0;
            was_extest      <= 1'b0;
            power_cycle_req <= 1'b0;
            recovery_req    <= 1'b0;
        end else begin
            rsp_valid <= done;
            if (done) begin
                rsp_data <= sh;
            end
            if (accept && req_ir) begin
                was_extest <= (safe_ir == bst_pkg::INS_EXTEST);
            end
            if (done && is_ir && was_extest) begin
                power_cycle_req <= 1'b1;
            end else if (power_cycle_done) begin
                power_cycle_req <= 1'b0;
            end
            if (done) begin
                recovery_req <= 1'b1;
            end else if (recovery_done) begin
                recovery_req <= 1'b0;
            end
        end
    end

    // Capture window stretched one test clock period past the edge
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_after <= 1'b0;
        end else if (rise_evt) begin
            cap_after <= (mirror == bst_pkg::CAP_DR);
        end
    end

    // Whole test clock period before and after the capture edge
    assign mem_hold_inputs = (mirror == bst_pkg::CAP_DR) ||
                             (bst_pkg::bst_next(mirror, tms_q) == bst_pkg::CAP_DR) ||
                             cap_after;

    assign tap.tck      = tck;
    assign tap.tms      = tms_q;
    assign tap.tdi      = tdi_q;
    assign tap.tms_oe_n = 1'b0;
    assign tap.tdi_oe_n = 1'b0;

endmodule // bst_tap_host

// ==== sim/bst_tap_asserts.sv ====
`timescale 1ns/10ps
// ****************************************
// Test link checks
// ****************************************
module bst_tap_asserts (
    // Clock and power-up reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Test pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tms_oe_n,
    input wire logic tdi_oe_n,
    input wire logic tdo,
    input wire logic tdo_oe_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic       tck_d;
    logic       last_tms;
    logic [2:0] ones;
    wire        rise = tck && !tck_d;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tck_d    <= 1'b0;
            last_tms <= 1'b1;
            ones     <= 3'h0;
        end else begin
            tck_d <= tck;
            if (rise) begin
                last_tms <= tms;
                ones     <= !tms ? 3'h0 : (ones == bst_pkg::RST_TMS_COUNT) ? ones : ones + 3'h1;
            end
        end
    end
    property p_tdo_fall; $changed(tdo) |-> !tck && ($past(tck, 2) || $past(tck, 3)); endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("data out moved off a falling edge");
    property p_oe_fall; $changed(tdo_oe_n) |-> !tck && ($past(tck, 2) || $past(tck, 3)); endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("data out enable moved off a falling edge");
    property p_tck_hi; $rose(tck) |-> tck[*3] ##1 !tck; endproperty
    a_tck_hi: assert property (p_tck_hi) else $error("test clock high time wrong");
    property p_tms_edge; $changed(tms) |-> !tck; endproperty
    a_tms_edge: assert property (p_tms_edge) else $error("mode select moved while clock high");
    property p_drive; !tms_oe_n && !tdi_oe_n; endproperty
    a_drive: assert property (p_drive) else $error("test inputs left undriven");
    property p_enter; $fell(tdo_oe_n) |-> !last_tms; endproperty
    a_enter: assert property (p_enter) else $error("shift entered with mode select high");
    property p_exit; $rose(tdo_oe_n) |-> last_tms; endproperty
    a_exit: assert property (p_exit) else $error("shift left with mode select low");
    property p_five; (ones == bst_pkg::RST_TMS_COUNT) |-> tdo_oe_n; endproperty
    a_five: assert property (p_five) else $error("data out driven after five high mode edges");
endmodule // bst_tap_asserts

// ==== sim/tb_sram_boundary_scan_tap.sv ====
`timescale 1ns/10ps
// ****************************************
// Bench
// ****************************************
module tb_sram_boundary_scan_tap;
    logic         ref_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_ir = 1'b0, core_oe_n = 1'b0;
    logic         power_cycle_done = 1'b0, recovery_done = 1'b0;
    logic         req_ready, rsp_valid, power_cycle_req, recovery_req, ball_oe_n, return_strobe_pos;
    logic         return_strobe_neg, hold;
    logic [3:0]   st;
    logic [6:0]   req_len = 7'h01;
    logic [108:0] req_data = '0, rsp_data, q, d, pre;
    logic [109:1] ball_in = '0, core_out = '0, ball_out;
    wire          both_c = ball_in[2] & ball_in[1];
    logic [2:0]   instr, c;
    logic [31:0]  seed = 32'h0000_09A2;
    int           bad_count = 0, samples_checked = 0;
    bst_if bif ();
    bst_tap_dev bst_tap_dev_i (.ref_clk, .reset_n, .tap(bif), .ball_in, .core_out, .core_oe_n, .ball_out,
        .ball_oe_n, .return_strobe_pos, .return_strobe_neg, .instr, .tap_state(st));
    bst_tap_host bst_tap_host_i (.ref_clk, .reset_n, .tap(bif), .req_valid, .req_ready, .req_ir, .req_len,
        .req_data, .rsp_valid, .rsp_data, .mem_hold_inputs(hold), .power_cycle_req, .power_cycle_done,
        .recovery_req, .recovery_done);
    bst_tap_asserts bst_tap_asserts_i (.ref_clk, .reset_n, .tck(bif.tck), .tms(bif.tms), .tms_oe_n(bif.tms_oe_n),
        .tdi_oe_n(bif.tdi_oe_n), .tdo(bif.tdo), .tdo_oe_n(bif.tdo_oe_n));
    initial forever #5 ref_clk = ~ref_clk;
    function automatic logic [108:0] nxt();
        logic [108:0] v;
        v = '0;
        repeat (4) begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            v = {v[76:0], seed};
        end
        return v;
    endfunction
    function automatic logic [108:0] exp_dr(input logic [2:0] k, input logic [108:0] v, input logic [109:1] b);
        case (k)
            3'h0, 3'h2, 3'h4: return {1'b0, b[108:1]};
            3'h1: return {v[76:0], bst_pkg::ID_VALUE};
            default: return {v[107:0], 1'b0};
        endcase
    endfunction
    task automatic chk(input string s, input logic [108:0] e, input logic [108:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", s, e, g);
            bad_count++;
        end
    endtask
    task automatic scan(input logic ir, input logic [6:0] n, input logic [108:0] v);
        int t;
        @(posedge ref_clk);
        req_ir <= ir;
        req_len <= n;
        req_data <= v;
        req_valid <= 1'b1;
        t = 0;
        do begin @(negedge ref_clk); t++; end while (req_ready !== 1'b1 && t < 9999);
        @(posedge ref_clk);
        req_valid <= 1'b0;
        do begin @(negedge ref_clk); t++; end while (rsp_valid !== 1'b1 && t < 9999);
        if (t >= 9999) bad_count++;
        q = rsp_data;
        chk("recovery", 1, recovery_req);
        @(posedge ref_clk);
        recovery_done <= 1'b1;
        @(posedge ref_clk);
        recovery_done <= 1'b0;
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(negedge ref_clk) begin
        if (reset_n && st == 4'(bst_pkg::CAP_DR)) chk("hold", 1, hold);
    end
    initial begin
        #400000;
        bad_count++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        scan(1'b0, 7'h20, '0);
        chk("idcode", bst_pkg::ID_VALUE, q[31:0]);
        chk("instr", bst_pkg::INS_IDCODE, instr);
        scan(1'b0, 7'h00, '1);
        chk("short id", bst_pkg::ID_VALUE[0], q[0]);
        for (int k = 7; k >= 0; k--) begin
            c = k[2:0];
            d = nxt();
            ball_in <= d | ((c == 3'h1) ? 109'h3 : 109'h0);
            core_out <= ~d;
            core_oe_n <= d[5];
            scan(1'b1, 7'h03, {106'h0, c});
            chk("ir capture", bst_pkg::IR_CAPTURE, q[2:0]);
            chk("instr", (c == 3'h3 || c == 3'h5 || c == 3'h6) ? 3'h7 : c, instr);
            chk("out enable", (c == 3'h2) ? 1'b1 : (c == 3'h0) ? 1'b0 : core_oe_n, ball_oe_n);
            if (c == 3'h0) chk("echo", pre[46], return_strobe_pos);
            else if (c != 3'h2) chk("echo", both_c ? ball_in[56] : ball_in[2], return_strobe_pos);
            if (c == 3'h0) chk("echo neg", pre[64], return_strobe_neg);
            else if (c != 3'h2) chk("echo neg", both_c ? ball_in[57] : ball_in[1], return_strobe_neg);
            chk("ball", (c == 3'h0) ? pre[9] : core_out[10], ball_out[10]);
            d = nxt();
            scan(1'b0, 7'h6D, d);
            chk("dr", exp_dr(c, d, ball_in), q);
            if (c == 3'h4) pre = d;
        end
        chk("power", 1, power_cycle_req);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        power_cycle_done <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        power_cycle_done <= 1'b0;
        scan(1'b0, 7'h20, '0);
        chk("instr", bst_pkg::INS_IDCODE, instr);
        chk("idcode", bst_pkg::ID_VALUE, q[31:0]);
        stop_test();
    end
endmodule // tb_sram_boundary_scan_tap
